//--- rtl/host_port_consts.svh
// offsets, field positions, reset values and lane counts of the host port
// assumes inclusion by bare name from the host port design files
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH

// host address word selects, taken from address bits [4:2]
`define WSEL_INDEX0    3'h0
`define WSEL_DATA0     3'h1
`define WSEL_INDEX1    3'h2
`define WSEL_DATA1     3'h3
`define WSEL_INDEX2    3'h4
`define WSEL_DATA2     3'h5
`define WSEL_BYPASS    3'h6
`define WSEL_CONFIG    3'h7

// host pin widths
`define HOST_ADDR_W    5
`define HOST_DATA_W    16

// conversion channel of direct fifo access (fifo select pin or bypass address)
`define FIFO_CHAN      2'h3

// index register reset value, doubles as a byte order probe
`define INDEX_RESET    16'h1234

// lanes that complete one dword in 16-bit and in 8-bit mode
`define LANES_WIDE     3'h2
`define LANES_BYTE     3'h4

// endianness field positions in the configuration byte
`define CFG_ENDIAN_LSB 0
`define CFG_ENDIAN_W   4

`endif

//--- rtl/host_port_pkg.sv
// types shared by the host port design files
// assumes host_port_consts.svh is on the include path
`include "host_port_consts.svh"

package host_port_pkg;

    // host bus cycle tracking
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_READ    = 3'b001,
        ST_WRITE   = 3'b010,
        ST_RD_SKIP = 3'b011,
        ST_WR_SKIP = 3'b100
    } cycle_state_type;

    // host pins as seen after synchronisation, active high
    typedef struct packed {
        logic                      cs;
        logic                      rd;
        logic                      wr;
        logic                      bus_enable_strobe;
        logic                      rdWr;
        logic                      fifo_direct_select;
        logic [`HOST_ADDR_W-1:0]   addr;
        logic [`HOST_DATA_W-1:0]   data;
    } host_pins_type;

    // one 32-bit internal write
    typedef struct packed {
        logic        fifo;
        logic [15:0] addr;
        logic [31:0] data;
    } int_wr_type;

    // internal read selection
    typedef struct packed {
        logic        fifo;
        logic [15:0] addr;
    } int_rd_type;

endpackage

//--- rtl/pin_sync3.sv
// three-stage synchroniser for asynchronous host pins
// assumes pins idle low; a change is taken once stages two and three agree
module pin_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] stable
);

    for (genvar gi = 0; gi < W; gi++) begin : g_bit
        logic s1;
        logic s2;
        logic s3;

        // stage one feeds only stage two, so no logic sees a metastable value
        always_ff @(posedge clk) begin
            if (rst) begin
                s1 <= 1'b0;
                s2 <= 1'b0;
                s3 <= 1'b0;
            end else begin
                s1 <= raw[gi];
                s2 <= s1;
                s3 <= s2;
            end
        end

        // agreement filter drops single-cycle glitches
        always_ff @(posedge clk) begin
            if (rst) begin
                stable[gi] <= 1'b0;
            end else if (s2 == s3) begin
                stable[gi] <= s3;
            end
        end
    end

endmodule

//--- rtl/dword_lane_unit.sv
// narrow-to-dword conversion for one data register or for direct fifo access
// assumes the caller pulses wrPulse/rdPulse on trailing edges and gives byte positions
`include "host_port_consts.svh"

module dword_lane_unit (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clear,
    input  wire logic        wide,
    input  wire logic        wrPulse,
    input  wire logic        rdPulse,
    input  wire logic [1:0]  pos,
    input  wire logic [15:0] hostData,
    output logic      [31:0] merged,
    output logic             wrLast,
    output logic             rdLast,
    output logic             lock
);

    logic [2:0]  wrCount;
    logic [2:0]  rdCount;
    logic [2:0]  target;
    logic [31:0] assembly;

    // two lanes in 16-bit mode, four in 8-bit mode
    assign target = wide ? `LANES_WIDE : `LANES_BYTE;
    assign wrLast = (wrCount + 3'h1) == target;
    assign rdLast = (rdCount + 3'h1) == target;

    // assembly register with the current lane patched in
    always_comb begin
        merged = assembly;
        if (wide) begin
            if (pos[1]) merged[31:16] = hostData;
            else        merged[15:0]  = hostData;
        end else begin
            case (pos)
                2'h0:    merged[7:0]   = hostData[7:0];
                2'h1:    merged[15:8]  = hostData[7:0];
                2'h2:    merged[23:16] = hostData[7:0];
                default: merged[31:24] = hostData[7:0];
            endcase
        end
    end

    // write lane counter; repeated lanes are not detected, the count just runs
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            wrCount <= 3'h0;
        end else if (wrPulse) begin
            wrCount <= wrLast ? 3'h0 : wrCount + 3'h1;
        end
    end

    // assembly restarts empty after each completed dword
    always_ff @(posedge clk) begin
        if (rst) begin
            assembly <= 32'h0;
        end else if (wrPulse) begin
            assembly <= wrLast ? 32'h0 : merged;
        end
    end

    // read lane counter, independent of the write side
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            rdCount <= 3'h0;
        end else if (rdPulse) begin
            rdCount <= rdLast ? 3'h0 : rdCount + 3'h1;
        end
    end

    // lock spans first to last lane; power drop releases it at once
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            lock <= 1'b0;
        end else if (rdPulse) begin
            lock <= ~rdLast;
        end
    end

endmodule

//--- rtl/host_bus_port.sv
// host bus port: 8/16-bit indexed host access to 32-bit internal registers
// assumes active-high host strobes, static mode inputs and a same-clock power state
`include "host_port_consts.svh"

module host_bus_port
    import host_port_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    csPin,
    input  wire logic                    rdPin,
    input  wire logic                    wrPin,
    input  wire logic                    enbPin,
    input  wire logic                    rdWrPin,
    input  wire logic                    fifoSelPin,
    input  wire logic [`HOST_ADDR_W-1:0] addrPin,
    input  wire logic [`HOST_DATA_W-1:0] dataIn,
    output logic      [`HOST_DATA_W-1:0] dataOut,
    output logic                         dataOe,
    input  wire logic                    enbMode,
    input  wire logic                    wideMode,
    input  wire logic                    fullPower,
    input  wire logic                    initDone,
    input  wire logic [31:0]             intRdData,
    output int_wr_type                   wrReq,
    output logic                         wrStrobe,
    output int_rd_type                   rdReq,
    output logic                         rdActive,
    output logic                         rdPop,
    output logic                         liveHold,
    output logic      [3:0]              laneLock
);

    host_pins_type   rawPins;
    host_pins_type   pins;
    cycle_state_type state;
    logic            cycRd;
    logic            cycWr;
    logic            armed;
    logic [3:0]      endian;
    logic [3:0][15:0] indexReg;

    // start-of-cycle decode from live pins
    logic [2:0]  wsel;
    logic [1:0]  startChan;
    logic        startData;
    logic        startCfg;
    logic        startBig;
    logic        leadRd;
    logic        leadWr;
    logic        rdTrail;
    logic        wrTrail;

    // values captured at the leading edge
    logic [1:0]  curChan;
    logic        curData;
    logic        curCfg;
    logic [1:0]  curPos;
    logic [15:0] curIndex;

    // per-channel conversion results
    logic [3:0][31:0] merged;
    logic [3:0]       wrLast;
    logic [3:0]       rdLast;
    logic [31:0]      srcWord;

    // byte position inside the little-endian dword for a host address
    function automatic logic [1:0] lanePos(input logic [1:0] a, input logic big,
                                           input logic wide);
        logic [1:0] p;
        p = big ? ~a : a;
        if (wide) begin
            p[0] = 1'b0;
        end
        return p;
    endfunction

    assign rawPins = {csPin, rdPin, wrPin, enbPin, rdWrPin, fifoSelPin, addrPin, dataIn};

    pin_sync3 #(.W($bits(host_pins_type))) u_sync (
        .clk    (clk),
        .rst    (rst),
        .raw    (rawPins),
        .stable (pins)
    );

    // cycle qualifiers for both strobe styles; mode is static
    always_comb begin
        if (enbMode) begin
            cycRd = pins.bus_enable_strobe & pins.rdWr;
            cycWr = pins.bus_enable_strobe & ~pins.rdWr;
        end else begin
            cycRd = pins.cs & pins.rd;
            cycWr = pins.cs & pins.wr;
        end
    end

    // address decode; data n and index n share channel n, bypass and fifo use 3
    always_comb begin
        wsel      = pins.addr[4:2];
        startCfg  = ~pins.fifo_direct_select & (wsel == `WSEL_CONFIG);
        startData = pins.fifo_direct_select | (~startCfg & (wsel[0] | (wsel == `WSEL_BYPASS)));
        startChan = pins.fifo_direct_select ? `FIFO_CHAN : wsel[2:1];
        startBig  = startCfg ? 1'b0 : endian[startChan];
    end

    assign leadRd  = (state == ST_IDLE) & cycRd;
    assign leadWr  = (state == ST_IDLE) & ~cycRd & cycWr;
    assign rdTrail = (state == ST_READ) & ~cycRd & fullPower;
    assign wrTrail = (state == ST_WRITE) & ~cycWr & fullPower;

    // cycle state; skipped cycles run to their own end untouched
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cycRd) state <= fullPower ? ST_READ : ST_RD_SKIP;
                    else if (cycWr) state <= (armed && fullPower) ? ST_WRITE : ST_WR_SKIP;
                end
                ST_READ: begin
                    if (!cycRd) state <= ST_IDLE;
                    else if (!fullPower) state <= ST_RD_SKIP;
                end
                ST_WRITE:   if (!cycWr) state <= ST_IDLE;
                ST_RD_SKIP: if (!cycRd) state <= ST_IDLE;
                ST_WR_SKIP: if (!cycWr) state <= ST_IDLE;
                default:    state <= ST_IDLE;
            endcase
        end
    end

    // write gate: armed only by a completed full-power read after init
    always_ff @(posedge clk) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (!fullPower || !initDone) begin
            armed <= 1'b0;
        end else if (rdTrail) begin
            armed <= 1'b1;
        end
    end

    // leading-edge capture of selection, address lane and index contents
    always_ff @(posedge clk) begin
        if (rst) begin
            curChan  <= 2'h0;
            curData  <= 1'b0;
            curCfg   <= 1'b0;
            curPos   <= 2'h0;
            curIndex <= 16'h0;
        end else if (leadRd || leadWr) begin
            curChan  <= startChan;
            curData  <= startData;
            curCfg   <= startCfg;
            curPos   <= lanePos(pins.addr[1:0], startBig, wideMode);
            curIndex <= indexReg[startChan];
        end
    end

    // internal read selection held for the whole read cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            rdReq <= '0;
        end else if (leadRd && fullPower && startData) begin
            rdReq.fifo <= (startChan == `FIFO_CHAN);
            rdReq.addr <= indexReg[startChan];
        end
    end

    // live bits are held from the first cycle of any full-power read
    always_ff @(posedge clk) begin
        if (rst) begin
            liveHold <= 1'b0;
            rdActive <= 1'b0;
        end else if (leadRd) begin
            liveHold <= fullPower;
            rdActive <= fullPower & startData;
        end else if (state != ST_READ || !cycRd || !fullPower) begin
            liveHold <= 1'b0;
            rdActive <= 1'b0;
        end
    end

    // one conversion unit per data register plus direct fifo
    for (genvar c = 0; c < 4; c++) begin : g_chan
        dword_lane_unit u_lane (
            .clk      (clk),
            .rst      (rst),
            .clear    (~fullPower),
            .wide     (wideMode),
            .wrPulse  (wrTrail & curData & (curChan == c)),
            .rdPulse  (rdTrail & curData & (curChan == c)),
            .pos      (curPos),
            .hostData (pins.data),
            .merged   (merged[c]),
            .wrLast   (wrLast[c]),
            .rdLast   (rdLast[c]),
            .lock     (laneLock[c])
        );
    end

    // one 32-bit internal write per completed dword
    always_ff @(posedge clk) begin
        if (rst) begin
            wrStrobe <= 1'b0;
            wrReq    <= '0;
        end else begin
            wrStrobe <= wrTrail & curData & wrLast[curChan];
            if (wrTrail && curData && wrLast[curChan]) begin
                wrReq.fifo <= (curChan == `FIFO_CHAN);
                wrReq.addr <= curIndex;
                wrReq.data <= merged[curChan];
            end
        end
    end

    // internal read pulse on the last lane so change-on-read registers update
    always_ff @(posedge clk) begin
        if (rst) begin
            rdPop <= 1'b0;
        end else begin
            rdPop <= rdTrail & curData & rdLast[curChan];
        end
    end

    // index registers take host lanes directly, no dword assembly
    always_ff @(posedge clk) begin
        if (rst) begin
            indexReg <= {16'h0, `INDEX_RESET, `INDEX_RESET, `INDEX_RESET};
        end else if (wrTrail && !curData && !curCfg && curChan != `FIFO_CHAN) begin
            if (wideMode) begin
                if (!curPos[1]) indexReg[curChan] <= pins.data;
            end else if (curPos == 2'h0) begin
                indexReg[curChan][7:0] <= pins.data[7:0];
            end else if (curPos == 2'h1) begin
                indexReg[curChan][15:8] <= pins.data[7:0];
            end
        end
    end

    // endianness bits are copied into every byte; in 16-bit mode a set copy in either byte sets the bit
    always_ff @(posedge clk) begin
        if (rst) begin
            endian <= 4'h0;
        end else if (wrTrail && curCfg) begin
            endian <= wideMode ? (pins.data[3:0] | pins.data[11:8]) : pins.data[3:0];
        end
    end

    // source dword for the read lane mux
    always_comb begin
        if (curData) srcWord = intRdData;
        else if (curCfg) srcWord = {4{4'h0, endian}};
        else srcWord = {16'h0, curIndex};
    end

    // pins are driven only while a full-power read is active
    always_ff @(posedge clk) begin
        if (rst) begin
            dataOe  <= 1'b0;
            dataOut <= 16'h0;
        end else begin
            dataOe <= (leadRd & fullPower) | ((state == ST_READ) & cycRd & fullPower);
            if (wideMode) dataOut <= curPos[1] ? srcWord[31:16] : srcWord[15:0];
            else begin
                case (curPos)
                    2'h0:    dataOut <= {8'h00, srcWord[7:0]};
                    2'h1:    dataOut <= {8'h00, srcWord[15:8]};
                    2'h2:    dataOut <= {8'h00, srcWord[23:16]};
                    default: dataOut <= {8'h00, srcWord[31:24]};
                endcase
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence sReadStart;
        (state == ST_IDLE) && cycRd && fullPower;
    endsequence

    sequence sLastRead;
        rdTrail && curData && rdLast[curChan];
    endsequence

    chk_write_gated: assert property (
        ((state == ST_IDLE) && !cycRd && cycWr && !armed) |=> (state == ST_WR_SKIP))
        else $error("write accepted while disarmed");

    chk_power_disarm: assert property (
        !fullPower |=> !armed ##1 (!armed || $past(rdTrail)))
        else $error("armed survived low power");

    chk_read_skipped: assert property (
        ((state == ST_IDLE) && cycRd && !fullPower) |=> (state == ST_RD_SKIP) && !liveHold)
        else $error("low power read not skipped");

    chk_live_hold: assert property (
        sReadStart |=> liveHold && (state == ST_READ))
        else $error("live bits not held at read start");

    chk_read_pop: assert property (
        sLastRead |=> rdPop ##1 !rdPop)
        else $error("last lane read gave no single internal read");

    chk_write_commit: assert property (
        wrStrobe |-> $past(wrTrail) && $past(wrLast[curChan]) && !$past(wrStrobe))
        else $error("internal write without final lane");

    chk_lock_release: assert property (
        !fullPower |=> (laneLock == 4'h0))
        else $error("lane lock held in low power");

    chk_pins_driven: assert property (
        sReadStart |=> dataOe [*1] ##1 (dataOe == $past(cycRd && fullPower)))
        else $error("data pins not driven during read");

    chk_no_oe_idle: assert property (
        ((state == ST_IDLE) && !cycRd) |=> !dataOe)
        else $error("data pins driven outside read");

endmodule

//--- dv/host_ctl_model.sv
// host controller model: drives the narrow host pins of the port, cs+rd/wr style
// assumes 8-bit hosts use the low data byte and strobes move on the falling clock edge
module host_ctl_model (
    input  wire logic        clk,
    input  wire logic [15:0] dataOut,
    input  wire logic        dataOe,
    output logic             csPin,
    output logic             rdPin,
    output logic             wrPin,
    output logic [4:0]       addrPin,
    output logic [15:0]      dataIn
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        csPin   = 1'b0;
        rdPin   = 1'b0;
        wrPin   = 1'b0;
        addrPin = 5'h00;
        dataIn  = 16'h0000;
    end

    // one host cycle; pins settle 5 clocks before the strobe and stay 6 after it
    // the caller keeps whole dwords, one write per lane, one pair per register,
    // and no read/write mix inside a dword
    task automatic busCycle(input logic isRead, input logic [4:0] a,
                            input logic [15:0] d, output logic [15:0] got,
                            output logic oe);
        @(negedge clk);
        addrPin <= a;
        if (!isRead) begin
            dataIn <= d;
        end
        repeat (5) @(negedge clk);
        csPin <= 1'b1;
        rdPin <= isRead;
        wrPin <= !isRead;
        repeat (8) @(negedge clk);
        got = dataOut;
        oe  = dataOe;
        csPin <= 1'b0;
        rdPin <= 1'b0;
        wrPin <= 1'b0;
        repeat (6) @(negedge clk);
        // a released bus does not keep its last value
        dataIn <= ~dataIn;
        repeat (2) @(negedge clk);
    endtask
endmodule

//--- dv/host_bus_port_tb_top.sv
// testbench for the host bus port: host cycles with expected internal traffic
// assumes host_ctl_model as the host and a constant internal read value
`define CHECK(what, exp, got) begin testsRun++; if ((got) !== (exp)) begin miscompares++; \
    $display("mismatch %s expected %h seen %h", what, exp, got); end end

module host_bus_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import host_port_pkg::*;

    logic        clk;
    logic        rst;
    logic        csPin, rdPin, wrPin;
    logic [4:0]  addrPin;
    logic [15:0] dataIn, dataOut, rdData;
    logic        dataOe, oeSeen, fullPower, initDone, wideMode;
    logic        wrStrobe, rdActive, rdPop, liveHold;
    logic [3:0]  laneLock;
    int_wr_type  wrReq, lastWr;
    int_rd_type  rdReq;
    int          miscompares, testsRun, wrCount, popCount, holdCycles, actCycles;

    host_ctl_model host (.clk(clk), .dataOut(dataOut), .dataOe(dataOe), .csPin(csPin),
        .rdPin(rdPin), .wrPin(wrPin), .addrPin(addrPin), .dataIn(dataIn));

    host_bus_port dut (.clk(clk), .rst(rst), .csPin(csPin), .rdPin(rdPin), .wrPin(wrPin),
        .enbPin(1'b0), .rdWrPin(1'b0), .fifoSelPin(1'b0), .addrPin(addrPin),
        .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .enbMode(1'b0),
        .wideMode(wideMode), .fullPower(fullPower), .initDone(initDone),
        .intRdData(32'h11223344), .wrReq(wrReq), .wrStrobe(wrStrobe), .rdReq(rdReq),
        .rdActive(rdActive), .rdPop(rdPop), .liveHold(liveHold), .laneLock(laneLock));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // tally internal writes and change-on-read pops as they leave the port
    always @(posedge clk) begin
        if (wrStrobe === 1'b1) begin
            wrCount++;
            lastWr = wrReq;
        end
        if (rdPop === 1'b1) begin
            popCount++;
        end
        // hold and active levels are counted in cycles; a read strobe spans 8
        if (liveHold === 1'b1) begin
            holdCycles++;
        end
        if (rdActive === 1'b1) begin
            actCycles++;
        end
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        host.busCycle(1'b0, a, d, rdData, oeSeen);
    endtask

    task automatic rd(input logic [4:0] a);
        host.busCycle(1'b1, a, 16'h0000, rdData, oeSeen);
    endtask

    // hang guard: far beyond the longest sequence below
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        rst = 1'b1;
        fullPower = 1'b1;
        initDone = 1'b1;
        wideMode = 1'b1;
        miscompares = 0;
        testsRun = 0;
        wrCount = 0;
        popCount = 0;
        holdCycles = 0;
        actCycles = 0;
        repeat (3) @(negedge clk);
        rst <= 1'b0;
        // writes before any read are dropped, the first read arms them
        wr(5'h04, 16'h1111);
        wr(5'h06, 16'h2222);
        `CHECK("write before read", 0, wrCount)
        rd(5'h00);
        `CHECK("index0 reset", 16'h1234, rdData)
        `CHECK("read drive", 1'b1, oeSeen)
        `CHECK("hold index read", 8, holdCycles)
        `CHECK("index not data", 0, actCycles)
        // data0 dword interleaved with a fifo bypass dword
        wr(5'h00, 16'h0010);
        wr(5'h04, 16'hbeef);
        wr(5'h18, 16'h5678);
        `CHECK("half dword", 0, wrCount)
        wr(5'h06, 16'hdead);
        `CHECK("data0 count", 1, wrCount)
        `CHECK("data0 write", {1'b0, 16'h0010, 32'hdeadbeef}, lastWr)
        wr(5'h1a, 16'h1234);
        `CHECK("fifo count", 2, wrCount)
        `CHECK("fifo write", {1'b1, 32'h12345678}, {lastWr.fifo, lastWr.data})
        // data0 read, low word then high word, one pop at the end
        rd(5'h04);
        `CHECK("read low", 16'h3344, rdData)
        `CHECK("read select", {1'b0, 16'h0010}, rdReq)
        `CHECK("lock first lane", 4'h1, laneLock)
        `CHECK("pop early", 0, popCount)
        rd(5'h06);
        `CHECK("read high", 16'h1122, rdData)
        `CHECK("pop last", 1, popCount)
        `CHECK("unlock last lane", 4'h0, laneLock)
        `CHECK("hold data reads", 24, holdCycles)
        `CHECK("data reads active", 16, actCycles)
        // data1 keeps its own read state; a power drop unlocks it
        rd(5'h0c);
        `CHECK("data1 select", {1'b0, 16'h1234}, rdReq)
        `CHECK("data1 lock", 4'h2, laneLock)
        // power drop: lane counters cleared, reads ignored, writes disarmed
        wr(5'h04, 16'haaaa);
        fullPower <= 1'b0;
        rd(5'h00);
        `CHECK("read low power", 1'b0, oeSeen)
        `CHECK("no hold low power", 32, holdCycles)
        `CHECK("lock released", 4'h0, laneLock)
        fullPower <= 1'b1;
        wr(5'h06, 16'hbbbb);
        `CHECK("disarmed write", 2, wrCount)
        rd(5'h00);
        `CHECK("index0 kept", 16'h0010, rdData)
        rd(5'h0e);
        `CHECK("read counter cleared", 1, popCount)
        rd(5'h0c);
        `CHECK("data1 pop", 2, popCount)
        wr(5'h06, 16'hcccc);
        `CHECK("counter cleared", 2, wrCount)
        wr(5'h04, 16'hdddd);
        `CHECK("fresh dword", 32'hccccdddd, lastWr.data)
        // big endian on pair 0 swaps the words
        wr(5'h1c, 16'h0001);
        wr(5'h04, 16'haaaa);
        wr(5'h06, 16'h5555);
        `CHECK("big endian write", 32'haaaa5555, lastWr.data)
        rd(5'h00);
        `CHECK("big endian index", 16'h0000, rdData)
        // second reset into 8-bit mode: four byte lanes, any order, per dword
        rst <= 1'b1;
        wideMode <= 1'b0;
        repeat (3) @(negedge clk);
        rst <= 1'b0;
        rd(5'h00);
        `CHECK("index0 byte", 16'h0034, rdData)
        wr(5'h04, 16'h0011);
        wr(5'h07, 16'h0044);
        wr(5'h05, 16'h0022);
        `CHECK("three bytes", 4, wrCount)
        wr(5'h06, 16'h0033);
        `CHECK("byte dword count", 5, wrCount)
        `CHECK("byte dword", {1'b0, 16'h1234, 32'h44332211}, lastWr)
        report_and_stop();
    end
endmodule
